/* logic/ckcfg_bank.sv */
// Purpose: configuration byte bank of a spread-spectrum clock generator
// Assumes: a protocol engine presents byte location, write strobe, data
// Notes: block read length from the read length byte
`timescale 1ns/1ps
`default_nettype none
`include "ckcfg_defines.svh"
module ckcfg_bank
   import ckcfg_pkg::*;
#(
   parameter logic [3:0] REV_CODE = 4'h1,  // arbitrary value
   parameter logic [3:0] MAKER_CODE = 4'h5,  // arbitrary value
   parameter logic [1:0] PART_KIND = 2'h0,
   parameter logic [5:0] PART_CODE = 6'h2A  // arbitrary value
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic strap_spread_i,
   input wire logic start_i,
   input wire logic [7:0] start_loc_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   output logic [4:0] read_length_o,
   output logic [1:0] spread_amount_o,
   output logic [3:0] edge_rate_o,
   output logic [1:0] swing_level_o,
   output logic [1:0] refclk_edge_rate_o,
   input wire logic powerdown_i,
   input wire logic [1:0] stop_state_i,
   output logic refclk_run_o,
   output logic [1:0] refclk_stop_level_o
);
   ckcfg_wr_if wif ();
   logic [7:0] b1;
   logic [7:0] b2;
   logic [7:0] b3;
   logic [7:0] b7;
   logic [1:0] rb;
   logic strap_done;
   logic [7:0] loc;
   logic rd_q;
   logic [2:0] rd_addr;
   ckcfg_strap u_strap (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .strap_pin_i(strap_spread_i),
      .spread_rb_o(rb),
      .done_o(strap_done)
   );
   ckcfg_store u_store (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .port(wif.store),
      .strap_spread_i(rb),
      .b1_o(b1),
      .b2_o(b2),
      .b3_o(b3),
      .b7_o(b7)
   );
   // location auto-increments per byte; stop after any byte keeps data
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) loc <= 8'h00;
      else if (start_i) loc <= start_loc_i;
      else if (wr_i || rd_i) loc <= loc + 8'h01;
   end
   wire loc_in_bank = loc[7:3] == 5'h00;
   assign wif.wr_en = wr_i && loc_in_bank && !start_i;
   assign wif.addr = loc[2:0];
   assign wif.wdata = wdata_i;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_q <= 1'b0;
         rd_addr <= 3'h0;
      end else begin
         rd_q <= rd_i && !start_i;
         rd_addr <= loc_in_bank ? loc[2:0] : 3'h0;
      end
   end
   function automatic logic [7:0] fixed_byte(input logic [2:0] a);
      case (a)
         `CKCFG_OFS_RSVD4: fixed_byte = `CKCFG_RST_RSVD4;
         `CKCFG_OFS_REVVEN: fixed_byte = {REV_CODE, MAKER_CODE};
         `CKCFG_OFS_PART: fixed_byte = {PART_KIND, PART_CODE};
         default: fixed_byte = 8'h00;
      endcase
   endfunction : fixed_byte
   wire is_fixed = rd_addr == `CKCFG_OFS_RSVD4
      || rd_addr == `CKCFG_OFS_REVVEN || rd_addr == `CKCFG_OFS_PART;
   // out-of-bank reads force address 0, so they return zero, not an alias
   wire [7:0] next_rdata = is_fixed ? fixed_byte(rd_addr)
      : rd_addr == 3'h0 ? 8'h00 : wif.rdata;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o <= 8'h00;
         rvalid_o <= 1'b0;
      end else begin
         rdata_o <= rd_q ? next_rdata : rdata_o;
         rvalid_o <= rd_q;
      end
   end
   // source of spread: strap copy or software field
   wire sw_sel = b1[`CKCFG_SEL_BIT];
   wire [1:0] sw_field = b1[`CKCFG_SW_HI:`CKCFG_SW_LO];
   wire [1:0] spread_src = sw_sel ? sw_field : rb;
   // odd codes carry spread; 10 is off, the high bit picks half or quarter
   wire [1:0] next_spread = !spread_src[0] ? 2'(CKCFG_SS_OFF)
      : spread_src[1] ? 2'(CKCFG_SS_HALF) : 2'(CKCFG_SS_QUARTER);
   // strap code 10 means quarter spread here, fixed by the strap block
   wire [1:0] strap_spread = rb == 2'h2 ? 2'(CKCFG_SS_QUARTER)
      : 2'(CKCFG_SS_OFF);
   wire ref_en = b3[`CKCFG_OE_BIT];
   wire ref_pd_keep = b3[`CKCFG_PD_BIT];
   wire next_ref_run = ref_en && (!powerdown_i || ref_pd_keep);
   // 00 and 10 both drive low
   wire [1:0] next_stop = stop_state_i == 2'h1 ? 2'(CKCFG_STOP_HIZ)
      : stop_state_i == 2'h3 ? 2'(CKCFG_STOP_HIGH) : 2'(CKCFG_STOP_LOW);
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         spread_amount_o <= 2'(CKCFG_SS_OFF);
         refclk_run_o <= 1'b0;
         refclk_stop_level_o <= 2'(CKCFG_STOP_LOW);
      end else begin
         spread_amount_o <= sw_sel ? next_spread : strap_spread;
         refclk_run_o <= strap_done && next_ref_run;
         refclk_stop_level_o <= next_stop;
      end
   end
   assign edge_rate_o = b2[3:0];
   assign swing_level_o = b1[1:0];
   assign refclk_edge_rate_o = b3[7:6];
   assign read_length_o = b7[4:0];
   // host duty: no on/off switching via software bits without reset

   a_rb_readonly: assert property (@(posedge clock_i) disable iff (!nrst_i)
      strap_done && wr_i && loc == 8'h01 |=> b1[7:6] == $past(rb))
      else $error("readback bits changed by write");
   a_sw_ignored: assert property (@(posedge clock_i) disable iff (!nrst_i)
      !sw_sel && $stable(rb) |=> spread_amount_o == $past(strap_spread))
      else $error("software spread acted without select");
   a_sw_decode: assert property (@(posedge clock_i) disable iff (!nrst_i)
      sw_sel && sw_field == 2'h2 |=> spread_amount_o == 2'(CKCFG_SS_OFF))
      else $error("code 10 must be spread off");
   a_sw_half: assert property (@(posedge clock_i) disable iff (!nrst_i)
      sw_sel && sw_field == 2'h3 |=> spread_amount_o == 2'(CKCFG_SS_HALF))
      else $error("code 11 must be half spread");
   a_edge_write: assert property (@(posedge clock_i) disable iff (!nrst_i)
      wif.wr_en && wif.addr == 3'h2 |=> edge_rate_o == $past(wdata_i[3:0]))
      else $error("edge rate write lost");
   a_ref_pd: assert property (@(posedge clock_i) disable iff (!nrst_i)
      strap_done && powerdown_i && !ref_pd_keep |=> !refclk_run_o)
      else $error("reference ran in power-down");
   a_ref_off: assert property (@(posedge clock_i) disable iff (!nrst_i)
      !ref_en |=> !refclk_run_o)
      else $error("reference ran while disabled");
   a_stop_hiz: assert property (@(posedge clock_i) disable iff (!nrst_i)
      stop_state_i == 2'h1 |=> refclk_stop_level_o == 2'(CKCFG_STOP_HIZ))
      else $error("stop level not high impedance");
   a_id_read: assert property (@(posedge clock_i) disable iff (!nrst_i)
      rd_i && !start_i && loc == 8'h05 |-> ##2
      rdata_o == {REV_CODE, MAKER_CODE} && rvalid_o)
      else $error("revision byte wrong");
   a_len_top: assert property (@(posedge clock_i) disable iff (!nrst_i)
      rd_i && !start_i && loc == 8'h07 |-> ##2 rdata_o[7:5] == 3'h0)
      else $error("read length top bits not zero");
   a_loc_step: assert property (@(posedge clock_i) disable iff (!nrst_i)
      !start_i && (wr_i || rd_i) |=> loc == $past(loc) + 8'h01)
      else $error("location did not advance");
   a_rsvd_read: assert property (@(posedge clock_i) disable iff (!nrst_i)
      rd_i && !start_i && loc == 8'h04 |-> ##2 rdata_o == 8'h40)
      else $error("reserved byte changed");
   c_sw_mode: cover property (@(posedge clock_i) sw_sel ##1 wr_i);
   c_block_rd: cover property (@(posedge clock_i) start_i ##1 rd_i [*3]);
   c_pd_keep: cover property (@(posedge clock_i)
      powerdown_i && ref_pd_keep && refclk_run_o);
endmodule : ckcfg_bank
`default_nettype wire

/* logic/ckcfg_defines.svh */
// Purpose: offsets, field positions, reset values for the config byte bank
// Assumes: byte-wide registers at their printed byte locations
// Notes: definitions only
`ifndef CKCFG_DEFINES_SVH
`define CKCFG_DEFINES_SVH
`define CKCFG_OFS_SPREAD 3'h1
`define CKCFG_OFS_EDGE 3'h2
`define CKCFG_OFS_REF 3'h3
`define CKCFG_OFS_RSVD4 3'h4
`define CKCFG_OFS_REVVEN 3'h5
`define CKCFG_OFS_PART 3'h6
`define CKCFG_OFS_RDLEN 3'h7
`define CKCFG_RST_SPREAD 8'h06
`define CKCFG_RST_EDGE 8'hFF
`define CKCFG_RST_REF 8'h5F
`define CKCFG_RST_RSVD4 8'h40
`define CKCFG_RST_RDLEN 8'h08
`define CKCFG_WMASK_SPREAD 8'h3B
`define CKCFG_WMASK_EDGE 8'h0F
`define CKCFG_WMASK_REF 8'hF0
`define CKCFG_WMASK_RDLEN 8'h1F
`define CKCFG_SEL_BIT 5
`define CKCFG_SW_HI 4
`define CKCFG_SW_LO 3
`define CKCFG_PD_BIT 5
`define CKCFG_OE_BIT 4
`define CKCFG_STRAP_SYNC 2
`endif

/* logic/ckcfg_pkg.sv */
// Purpose: types for the config byte bank
// Assumes: nothing
// Notes: spread levels, stop levels
package ckcfg_pkg;
   typedef enum logic [1:0] {CKCFG_SS_OFF, CKCFG_SS_QUARTER,
      CKCFG_SS_HALF} ckcfg_spread_e;
   typedef enum logic [1:0] {CKCFG_STOP_LOW, CKCFG_STOP_HIZ,
      CKCFG_STOP_HIGH} ckcfg_stop_e;
   typedef logic [7:0] ckcfg_byte_t;
endpackage : ckcfg_pkg

/* logic/ckcfg_store.sv */
// Purpose: byte store for the writable configuration bytes
// Assumes: masks from header keep read-only bits at reset value, except the b1 readback pair, which follows the strap
// Notes: read data registered
`timescale 1ns/1ps
`default_nettype none
`include "ckcfg_defines.svh"
module ckcfg_store
   import ckcfg_pkg::*;
(
   input wire logic clock_i,
   input wire logic nrst_i,
   ckcfg_wr_if.store port,
   input wire logic [1:0] strap_spread_i,
   output logic [7:0] b1_o,
   output logic [7:0] b2_o,
   output logic [7:0] b3_o,
   output logic [7:0] b7_o
);
   logic [7:0] b1;
   logic [7:0] b2;
   logic [7:0] b3;
   logic [7:0] b7;
   logic [7:0] rd;
   function automatic logic [7:0] merge(input logic [7:0] old,
      input logic [7:0] nw, input logic [7:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction : merge
   wire sel1 = port.wr_en && port.addr == `CKCFG_OFS_SPREAD;
   wire sel2 = port.wr_en && port.addr == `CKCFG_OFS_EDGE;
   wire sel3 = port.wr_en && port.addr == `CKCFG_OFS_REF;
   wire sel7 = port.wr_en && port.addr == `CKCFG_OFS_RDLEN;
   wire [7:0] next_b1 = merge(b1, port.wdata,
      sel1 ? `CKCFG_WMASK_SPREAD : 8'h00);
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         b1 <= `CKCFG_RST_SPREAD;
         b2 <= `CKCFG_RST_EDGE;
         b3 <= `CKCFG_RST_REF;
         b7 <= `CKCFG_RST_RDLEN;
      end else begin
         // readback bits follow the latched strap, never a write
         b1 <= {strap_spread_i, next_b1[5:0]};
         if (sel2) b2 <= merge(b2, port.wdata, `CKCFG_WMASK_EDGE);
         if (sel3) b3 <= merge(b3, port.wdata, `CKCFG_WMASK_REF);
         if (sel7) b7 <= merge(b7, port.wdata, `CKCFG_WMASK_RDLEN);
      end
   end
   always_comb begin
      case (port.addr)
         `CKCFG_OFS_SPREAD: rd = b1;
         `CKCFG_OFS_EDGE: rd = b2;
         `CKCFG_OFS_REF: rd = b3;
         `CKCFG_OFS_RDLEN: rd = b7;
         default: rd = 8'h00;
      endcase
   end
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) port.rdata <= 8'h00;
      else port.rdata <= rd;
   end
   assign b1_o = b1;
   assign b2_o = b2;
   assign b3_o = b3;
   assign b7_o = b7;
endmodule : ckcfg_store
`default_nettype wire

/* logic/ckcfg_strap.sv */
// Purpose: capture the spread strap once after reset release
// Assumes: strap pin is asynchronous, steady at power-up
// Notes: two-stage synchroniser, then one capture
`timescale 1ns/1ps
`default_nettype none
`include "ckcfg_defines.svh"
module ckcfg_strap (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic strap_pin_i,
   output logic [1:0] spread_rb_o,
   output logic done_o
);
   logic s1;
   logic s2;
   logic [1:0] settle;
   wire synced = settle == 2'(`CKCFG_STRAP_SYNC);
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         settle <= 2'h0;
         done_o <= 1'b0;
         spread_rb_o <= 2'h0;
      end else begin
         s1 <= strap_pin_i;
         s2 <= s1;
         // wait until s2 holds the pin, not its reset value
         if (!synced) settle <= settle + 2'h1;
         if (synced && !done_o) done_o <= 1'b1;
         // latch once; later pin motion is ignored
         if (synced && !done_o) spread_rb_o <= s2 ? 2'h2 : 2'h0;
      end
   end
endmodule : ckcfg_strap
`default_nettype wire

/* logic/ckcfg_wr_if.sv */
// Purpose: write and read port between bank and byte store
// Assumes: one clock
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface ckcfg_wr_if;
   logic wr_en;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport bank (output wr_en, output addr, output wdata, input rdata);
   modport store (input wr_en, input addr, input wdata, output rdata);
endinterface : ckcfg_wr_if
`default_nettype wire

/* verif/ckcfg_host.sv */
// Purpose: host side model presenting byte transfers to the bank
// Assumes: one strobe per clock, driven just after the rising edge
// Notes: idle lines are scrambled so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module ckcfg_host (
   input wire logic clock_i,
   output logic start_o,
   output logic [7:0] loc_o,
   output logic wr_o,
   output logic [7:0] wdata_o,
   output logic rd_o
);
   initial begin
      start_o = 1'b0;
      wr_o = 1'b0;
      rd_o = 1'b0;
      loc_o = 8'h00;
      wdata_o = 8'h00;
   end
   // start location first, then consecutive bytes
   task automatic begin_at(input logic [7:0] n);
      @(posedge clock_i);
      start_o <= 1'b1;
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      loc_o <= n;
   endtask : begin_at
   task automatic put(input logic [7:0] d);
      @(posedge clock_i);
      start_o <= 1'b0;
      wr_o <= 1'b1;
      rd_o <= 1'b0;
      wdata_o <= d;
      loc_o <= ~loc_o;
   endtask : put
   task automatic get();
      @(posedge clock_i);
      start_o <= 1'b0;
      wr_o <= 1'b0;
      rd_o <= 1'b1;
      wdata_o <= ~wdata_o;
   endtask : get
   task automatic idle();
      @(posedge clock_i);
      start_o <= 1'b0;
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      wdata_o <= ~wdata_o;
      loc_o <= ~loc_o;
   endtask : idle
endmodule : ckcfg_host
`default_nettype wire

/* verif/clock_gen_config_bytes_bench.sv */
// Purpose: self-checking bench for the config byte bank
// Assumes: host model drives strobes, bench drives strap and levels
// Notes: read data checked against a queue of expected bytes
`timescale 1ns/1ps
`default_nettype none
`include "ckcfg_defines.svh"
module clock_gen_config_bytes_bench import ckcfg_pkg::*;;
   localparam logic [3:0] REV = 4'h9; // arbitrary value
   localparam logic [3:0] MAK = 4'h6; // arbitrary value
   localparam logic [5:0] PCODE = 6'h15; // arbitrary value
   localparam logic [1:0] PKIND = 2'h3; // arbitrary value
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic strap = 1'b0;
   logic pd;
   logic [1:0] stop;
   logic start, wr, rd, rvalid, run;
   logic [7:0] loc, wdata, rdata;
   logic [4:0] rlen;
   logic [1:0] amt, swing, rrate, slvl;
   logic [3:0] edge_rate;
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;
   ckcfg_byte_t exp_q[$];
   ckcfg_byte_t cur[8];
   ckcfg_byte_t msk[8] = '{8'h00, 8'h3B, 8'h0F, 8'hF0, 8'h00, 8'h00, 8'h00,
      8'h1F};
   initial begin
      forever #2.5 clock_i = ~clock_i;
   end
   ckcfg_host u_ckcfg_host (.clock_i(clock_i), .start_o(start), .loc_o(loc),
      .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
   ckcfg_bank #(.REV_CODE(REV), .MAKER_CODE(MAK), .PART_KIND(PKIND),
      .PART_CODE(PCODE)) u_ckcfg_bank (.clock_i(clock_i), .nrst_i(nrst_i),
      .strap_spread_i(strap), .start_i(start), .start_loc_i(loc),
      .wr_i(wr), .wdata_i(wdata), .rd_i(rd), .rdata_o(rdata),
      .rvalid_o(rvalid), .read_length_o(rlen), .spread_amount_o(amt),
      .edge_rate_o(edge_rate), .swing_level_o(swing),
      .refclk_edge_rate_o(rrate), .powerdown_i(pd), .stop_state_i(stop),
      .refclk_run_o(run), .refclk_stop_level_o(slvl));
   task automatic check(input string what, input logic [7:0] e,
      input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", what, e, g);
         errors++;
      end
   endtask : check
   task automatic stop_test();
      $display("compared %0d mismatched %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   function automatic logic [1:0] code3(input logic [1:0] c);
      return (c == 2'h3) ? 2'h2 : ((c == 2'h1) ? 2'h1 : 2'h0);
   endfunction : code3
   // power-up image of the bank, strap decides the readback pair
   task automatic do_reset(input logic s);
      @(posedge clock_i);
      nrst_i <= 1'b0;
      strap <= s;
      repeat (2) @(posedge clock_i);
      nrst_i <= 1'b1;
      cur = '{8'h00, {s, 1'b0, 6'h06}, 8'hFF, 8'h5F, 8'h40, {REV, MAK},
         {PKIND, PCODE}, 8'h08};
      repeat (4) @(posedge clock_i);
   endtask : do_reset
   task automatic read_all(input int first, input int last);
      u_ckcfg_host.begin_at(8'(first));
      for (int n = first; n <= last; n++) begin
         u_ckcfg_host.get();
         exp_q.push_back((n < 8) ? cur[n] : 8'h00);
      end
      u_ckcfg_host.idle();
      for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge clock_i);
   endtask : read_all
   task automatic write_one(input int n, input logic [7:0] w);
      u_ckcfg_host.begin_at(8'(n));
      u_ckcfg_host.put(w);
      u_ckcfg_host.idle();
      cur[n] = (cur[n] & ~msk[n]) | (w & msk[n]);
      repeat (3) @(posedge clock_i);
   endtask : write_one
   always @(posedge clock_i) begin
      if (rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            $display("unexpected rdata expected none seen %h", rdata);
            errors++;
         end else begin
            check("rdata", exp_q.pop_front(), rdata);
         end
      end
   end
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      logic [7:0] w;
      logic [2:0] v;
      void'($urandom(32'hE3709EAF));
      pd <= 1'b0;
      stop <= 2'h0;
      do_reset(1'b0);
      read_all(0, 8);
      check("spread", 8'(2'h0), 8'(amt));
      $display("test power-up image done");
      for (int r = 0; r < 6; r++) begin
         u_ckcfg_host.begin_at(8'h01);
         for (int n = 1; n < 8; n++) begin
            w = 8'($urandom());
            u_ckcfg_host.put(w);
            cur[n] = (cur[n] & ~msk[n]) | (w & msk[n]);
         end
         u_ckcfg_host.idle();
         repeat (3) @(posedge clock_i);
         read_all(1, 7);
         check("edge", 8'(cur[2][3:0]), 8'(edge_rate));
         check("refrate", 8'(cur[3][7:6]), 8'(rrate));
         check("swing", 8'(cur[1][1:0]), 8'(swing));
         check("length", 8'(cur[7][4:0]), 8'(rlen));
      end
      $display("test random fill done");
      for (int i = 0; i < 8; i++) begin
         v = 3'(i);
         write_one(1, {2'h0, v, 3'h6});
         check("spread", 8'(v[2] ? code3(v[1:0]) : 2'h0), 8'(amt));
      end
      do_reset(1'b1);
      read_all(1, 1);
      check("spread", 8'(2'h1), 8'(amt));
      write_one(1, 8'h1E);
      check("spread", 8'(2'h1), 8'(amt));
      $display("test spread select done");
      for (int i = 0; i < 32; i++) begin
         write_one(3, {2'h1, i[1], i[0], 4'hF});
         pd <= i[2];
         stop <= 2'(i >> 3);
         repeat (3) @(posedge clock_i);
         check("run", 8'(i[0] & (~i[2] | i[1])), 8'(run));
         if (!(i[0] & (~i[2] | i[1]))) begin
            check("stoplvl", 8'(code3(2'(i >> 3))), 8'(slvl));
         end
      end
      $display("test reference control done");
      u_ckcfg_host.begin_at(8'h02);
      u_ckcfg_host.put(8'h05);
      u_ckcfg_host.begin_at(8'h07);
      u_ckcfg_host.put(8'h13);
      u_ckcfg_host.idle();
      cur[2] = 8'hF5;
      cur[7] = 8'h13;
      read_all(2, 7);
      $display("test abort done");
      stop_test();
   end
endmodule : clock_gen_config_bytes_bench
`default_nettype wire
